// >>> verilog/pltq_defs.vh
`ifndef PLTQ_DEFS_VH
`define PLTQ_DEFS_VH

`define PLTQ_OFF_CTRL 6'h00
`define PLTQ_OFF_LOGIC 6'h04
`define PLTQ_OFF_PULSE 6'h08
`define PLTQ_OFF_GLITCH_W 6'h0C
`define PLTQ_OFF_LOWER_W 6'h10
`define PLTQ_OFF_UPPER_W 6'h14
`define PLTQ_OFF_TIMEOUT_W 6'h18
`define PLTQ_OFF_PATTERN_W 6'h1C
`define PLTQ_OFF_PULSE_THR 6'h20
`define PLTQ_OFF_LOGIC_THR 6'h24
`define PLTQ_OFF_STATUS 6'h28

`define PLTQ_TYPE_EDGE 2'h0
`define PLTQ_TYPE_LOGIC 2'h1
`define PLTQ_TYPE_PULSE 2'h2
`define PLTQ_CLASS_GLITCH 2'h0
`define PLTQ_CLASS_WIDTH 2'h1
`define PLTQ_CLASS_TIMEOUT 2'h2
`define PLTQ_POL_POS 2'h0
`define PLTQ_POL_NEG 2'h1
`define PLTQ_POL_EITHER 2'h2
`define PLTQ_FN_AND 2'h0
`define PLTQ_FN_NAND 2'h1
`define PLTQ_FN_OR 2'h2
`define PLTQ_FN_NOR 2'h3
`define PLTQ_QUAL_OFF 2'h0
`define PLTQ_QUAL_WIDER 2'h1
`define PLTQ_QUAL_NARROWER 2'h2

`define PLTQ_ST_IDLE 2'h0
`define PLTQ_ST_ARMING 2'h1
`define PLTQ_ST_ARMED 2'h2

`define PLTQ_CLK_NS 10
`define PLTQ_WIDTH_MIN_NS 1
`define PLTQ_WIDTH_MAX_NS 1000000000
`define PLTQ_WIDTH_MIN_CYC ((`PLTQ_WIDTH_MIN_NS + `PLTQ_CLK_NS - 1) / `PLTQ_CLK_NS)
`define PLTQ_WIDTH_MAX_CYC (`PLTQ_WIDTH_MAX_NS / `PLTQ_CLK_NS)

`define PLTQ_RST_WIDTH 32'h00000010
`define PLTQ_RST_UPPER 32'h00000020
`define PLTQ_RST_THR 8'h80

`endif

// >>> verilog/pulse_logic_trigger_qualifier.v
`timescale 1ns/10ps
`include "pltq_defs.vh"
module pulse_logic_trigger_qualifier #(
  parameter WIDTH_W = 28,
  parameter SAMPLE_W = 8,
  parameter FOUR_CHAN = 1
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst_b,
  // Avalon-MM slave, byte address
  input wire [5:0] i_avs_address,
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [3:0] i_avs_byteenable,
  output reg [31:0] o_avs_readdata,
  output reg o_avs_waitrequest,
  // Monitored channels
  input wire [4*SAMPLE_W-1:0] i_chan_sample,
  input wire i_outside_trigger_input,
  // Trigger result
  output reg o_trigger,
  output reg o_armed
);

  localparam [3:0] CHAN_MASK = (FOUR_CHAN != 0) ? 4'hF : 4'h3;
  localparam [WIDTH_W-1:0] CNT_MAX = {WIDTH_W{1'b1}};
  localparam [31:0] MIN_CYC = `PLTQ_WIDTH_MIN_CYC;
  localparam [31:0] MAX_CYC = `PLTQ_WIDTH_MAX_CYC;
  localparam [31:0] RST_W = `PLTQ_RST_WIDTH;
  localparam [31:0] RST_UP = `PLTQ_RST_UPPER;
  // Control
  reg [1:0] trig_type;
  reg [1:0] src_sel;
  reg use_outside;
  reg [1:0] sec_type;
  reg [1:0] arm_st;
  reg trig_seen;
  // Logic setup
  reg [3:0] cond_high;
  reg [3:0] cond_care;
  reg [1:0] log_func;
  reg log_state;
  reg log_slope;
  reg [1:0] log_qual;
  // Pulse setup
  reg [1:0] pul_class;
  reg [1:0] gl_pol;
  reg wd_pol;
  reg to_pol;
  reg narrower_than_select;
  reg wd_outside;
  reg [WIDTH_W-1:0] gl_width;
  reg [WIDTH_W-1:0] lower_width_bound;
  reg [WIDTH_W-1:0] upper_width_bound;
  reg [WIDTH_W-1:0] to_width;
  reg [WIDTH_W-1:0] pat_width;
  reg [SAMPLE_W-1:0] pulse_thr;
  reg [4*SAMPLE_W-1:0] logic_thr;
  // Measurement
  reg lvl_q;
  reg meas_valid;
  reg [WIDTH_W-1:0] cnt;
  reg [3:0] lg_q;
  reg pf_q;
  reg [WIDTH_W-1:0] tcnt;
  // Width limits are held in clock cycles, clamped to the legal range
  function [WIDTH_W-1:0] clamp_width;
    input [31:0] v;
    begin
      if (v < MIN_CYC) begin
        clamp_width = MIN_CYC[WIDTH_W-1:0];
      end else if (v > MAX_CYC) begin
        clamp_width = MAX_CYC[WIDTH_W-1:0];
      end else begin
        clamp_width = v[WIDTH_W-1:0];
      end
    end
  endfunction
  function logic_fn;
    input [3:0] lv;
    input [3:0] hi;
    input [3:0] care;
    input [1:0] fn;
    reg [3:0] met;
    begin
      met = ~(lv ^ hi);
      case (fn)
        `PLTQ_FN_AND: logic_fn = &(met | ~care);
        `PLTQ_FN_NAND: logic_fn = ~(&(met | ~care));
        `PLTQ_FN_OR: logic_fn = |(met & care);
        `PLTQ_FN_NOR: logic_fn = ~(|(met & care));
        default: logic_fn = 1'b0;
      endcase
    end
  endfunction
  function [31:0] pad_width;
    input [WIDTH_W-1:0] w;
    begin
      pad_width = {{(32-WIDTH_W){1'b0}}, w};
    end
  endfunction

  // Register read mux, also the base for byte-enable merging
  reg [31:0] rd_word;
  always @* begin
    case (i_avs_address)
      `PLTQ_OFF_CTRL: rd_word = {22'h0, sec_type, 1'b0, use_outside, src_sel, trig_type, 2'h0};
      `PLTQ_OFF_LOGIC: rd_word = {18'h0, log_qual, log_slope, log_state, log_func,
                                  cond_care, cond_high};
      `PLTQ_OFF_PULSE: rd_word = {24'h0, wd_outside, narrower_than_select, to_pol, wd_pol,
                                  gl_pol, pul_class};
      `PLTQ_OFF_GLITCH_W: rd_word = pad_width(gl_width);
      `PLTQ_OFF_LOWER_W: rd_word = pad_width(lower_width_bound);
      `PLTQ_OFF_UPPER_W: rd_word = pad_width(upper_width_bound);
      `PLTQ_OFF_TIMEOUT_W: rd_word = pad_width(to_width);
      `PLTQ_OFF_PATTERN_W: rd_word = pad_width(pat_width);
      `PLTQ_OFF_PULSE_THR: rd_word = {{(32-SAMPLE_W){1'b0}}, pulse_thr};
      `PLTQ_OFF_LOGIC_THR: rd_word = logic_thr[31:0];
      `PLTQ_OFF_STATUS: rd_word = {26'h0, meas_valid, lvl_q, (FOUR_CHAN != 0), trig_seen,
                                   arm_st};
      default: rd_word = 32'h00000000;
    endcase
  end

  wire [31:0] be_mask = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
                         {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
  wire [31:0] wr_word = (rd_word & ~be_mask) | (i_avs_writedata & be_mask);
  // A write lands at the edge where waitrequest is seen low
  wire wr_go = i_avs_write & ~o_avs_waitrequest;
  wire cfg_change = wr_go & (i_avs_address != `PLTQ_OFF_STATUS);
  wire arm_cmd = wr_go & (i_avs_address == `PLTQ_OFF_CTRL) & wr_word[0];
  wire disarm_cmd = wr_go & (i_avs_address == `PLTQ_OFF_CTRL) & wr_word[1];
  // Partial measurements are dropped on reconfiguration and while arming
  wire meas_clr = cfg_change | (arm_st == `PLTQ_ST_ARMING);

  // Avalon handshake: one wait state, then the answer
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= 32'h00000000;
    end else if ((i_avs_read | i_avs_write) & o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b0;
      o_avs_readdata <= i_avs_read ? rd_word : o_avs_readdata;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  // Configuration registers
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      trig_type <= `PLTQ_TYPE_EDGE;
      src_sel <= 2'h0;
      use_outside <= 1'b0;
      sec_type <= `PLTQ_TYPE_EDGE;
      cond_high <= 4'h0;
      cond_care <= 4'h0;
      log_func <= `PLTQ_FN_AND;
      log_state <= 1'b0;
      log_slope <= 1'b0;
      log_qual <= `PLTQ_QUAL_OFF;
      pul_class <= `PLTQ_CLASS_GLITCH;
      gl_pol <= `PLTQ_POL_POS;
      wd_pol <= 1'b0;
      to_pol <= 1'b0;
      narrower_than_select <= 1'b0;
      wd_outside <= 1'b0;
      gl_width <= RST_W[WIDTH_W-1:0];
      lower_width_bound <= RST_W[WIDTH_W-1:0];
      upper_width_bound <= RST_UP[WIDTH_W-1:0];
      to_width <= RST_W[WIDTH_W-1:0];
      pat_width <= RST_W[WIDTH_W-1:0];
      pulse_thr <= `PLTQ_RST_THR;
      logic_thr <= {4{`PLTQ_RST_THR}};
    end else if (wr_go) begin
      case (i_avs_address)
        `PLTQ_OFF_CTRL: begin
          if (wr_word[3:2] != 2'h3) begin
            trig_type <= wr_word[3:2];
          end
          src_sel <= wr_word[5:4];
          use_outside <= wr_word[6];
          if (wr_word[9:8] == `PLTQ_TYPE_EDGE) begin
            sec_type <= wr_word[9:8];
          end
        end
        `PLTQ_OFF_LOGIC: begin
          cond_high <= wr_word[3:0];
          cond_care <= wr_word[7:4];
          log_func <= wr_word[9:8];
          log_state <= wr_word[10] & (FOUR_CHAN != 0);
          log_slope <= wr_word[11];
          if (wr_word[13:12] != 2'h3) begin
            log_qual <= wr_word[13:12];
          end
        end
        `PLTQ_OFF_PULSE: begin
          if (wr_word[1:0] != 2'h3) begin
            pul_class <= wr_word[1:0];
          end
          if (wr_word[3:2] != 2'h3) begin
            gl_pol <= wr_word[3:2];
          end
          wd_pol <= wr_word[4];
          to_pol <= wr_word[5];
          narrower_than_select <= wr_word[6];
          wd_outside <= wr_word[7];
        end
        `PLTQ_OFF_GLITCH_W: gl_width <= clamp_width(wr_word);
        `PLTQ_OFF_LOWER_W: lower_width_bound <= clamp_width(wr_word);
        `PLTQ_OFF_UPPER_W: upper_width_bound <= clamp_width(wr_word);
        `PLTQ_OFF_TIMEOUT_W: to_width <= clamp_width(wr_word);
        `PLTQ_OFF_PATTERN_W: pat_width <= clamp_width(wr_word);
        `PLTQ_OFF_PULSE_THR: pulse_thr <= wr_word[SAMPLE_W-1:0];
        `PLTQ_OFF_LOGIC_THR: logic_thr <= wr_word[4*SAMPLE_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Threshold comparators for the logic inputs
  wire [3:0] lg_now;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_cmp
      assign lg_now[gi] = i_chan_sample[gi*SAMPLE_W +: SAMPLE_W] >
                          logic_thr[gi*SAMPLE_W +: SAMPLE_W];
    end
  endgenerate

  // Pulse source against the one shared threshold
  wire [SAMPLE_W-1:0] src_sample = i_chan_sample[src_sel*SAMPLE_W +: SAMPLE_W];
  wire lvl_now = use_outside ? i_outside_trigger_input : (src_sample > pulse_thr);
  wire edge_seen = lvl_now ^ lvl_q;
  // At an edge the ending pulse was positive when the level had been high
  wire ended_pos = lvl_q;

  reg gl_pol_ok;
  always @* begin
    case (gl_pol)
      `PLTQ_POL_POS: gl_pol_ok = ended_pos;
      `PLTQ_POL_NEG: gl_pol_ok = ~ended_pos;
      `PLTQ_POL_EITHER: gl_pol_ok = 1'b1;
      default: gl_pol_ok = 1'b0;
    endcase
  end

  wire gl_hit = edge_seen & meas_valid & gl_pol_ok &
                (narrower_than_select ? (cnt < gl_width) : (cnt > gl_width));
  wire in_range = (cnt >= lower_width_bound) & (cnt <= upper_width_bound);
  wire wd_hit = edge_seen & meas_valid & (ended_pos ^ wd_pol) &
                (wd_outside ? ~in_range : in_range);
  wire to_short = edge_seen & meas_valid & (ended_pos ^ to_pol) & (cnt < to_width);
  wire to_force = ~edge_seen & meas_valid & (lvl_q ^ to_pol) & (cnt == to_width);

  reg pulse_hit;
  always @* begin
    case (pul_class)
      `PLTQ_CLASS_GLITCH: pulse_hit = gl_hit;
      `PLTQ_CLASS_WIDTH: pulse_hit = wd_hit;
      `PLTQ_CLASS_TIMEOUT: pulse_hit = to_short | to_force;
      default: pulse_hit = 1'b0;
    endcase
  end

  // Logic trigger evaluation; the outside input plays no part here
  wire [3:0] care_eff = cond_care & CHAN_MASK & (log_state ? 4'h7 : 4'hF);
  wire pf_now = logic_fn(lg_now, cond_high, care_eff, log_func);
  wire clk4_edge = log_slope ? (lg_q[3] & ~lg_now[3]) : (~lg_q[3] & lg_now[3]);
  wire state_hit = log_state & clk4_edge & pf_now;
  reg pat_hit;
  always @* begin
    case (log_qual)
      `PLTQ_QUAL_OFF: pat_hit = pf_now & ~pf_q;
      `PLTQ_QUAL_WIDER: pat_hit = pf_now & (tcnt == pat_width);
      `PLTQ_QUAL_NARROWER: pat_hit = ~pf_now & pf_q & (tcnt < pat_width);
      default: pat_hit = 1'b0;
    endcase
  end

  reg any_hit;
  always @* begin
    case (trig_type)
      `PLTQ_TYPE_EDGE: any_hit = meas_valid & edge_seen & lvl_now;
      `PLTQ_TYPE_LOGIC: any_hit = log_state ? state_hit : pat_hit;
      `PLTQ_TYPE_PULSE: any_hit = pulse_hit;
      default: any_hit = 1'b0;
    endcase
  end

  // Width counters saturate so a stuck level never wraps into a match
  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lvl_q <= 1'b0;
      meas_valid <= 1'b0;
      cnt <= {WIDTH_W{1'b0}};
      lg_q <= 4'h0;
      pf_q <= 1'b1;
      tcnt <= {WIDTH_W{1'b0}};
    end else begin
      lvl_q <= lvl_now;
      lg_q <= lg_now;
      if (meas_clr) begin
        meas_valid <= 1'b0;
        cnt <= {WIDTH_W{1'b0}};
        pf_q <= 1'b1;
        tcnt <= {WIDTH_W{1'b0}};
      end else begin
        if (edge_seen) begin
          meas_valid <= 1'b1;
          cnt <= {{(WIDTH_W-1){1'b0}}, 1'b1};
        end else if (cnt != CNT_MAX) begin
          cnt <= cnt + 1'b1;
        end
        pf_q <= pf_now;
        if (pf_now & ~pf_q) begin
          tcnt <= {{(WIDTH_W-1){1'b0}}, 1'b1};
        end else if (pf_now & (tcnt != CNT_MAX)) begin
          tcnt <= tcnt + 1'b1;
        end
      end
    end
  end

  // Arm sequence: single shot, back to idle after one trigger
  reg [1:0] next_arm_st;
  always @* begin
    next_arm_st = arm_st;
    case (arm_st)
      `PLTQ_ST_IDLE: begin
        if (arm_cmd) begin
          next_arm_st = `PLTQ_ST_ARMING;
        end
      end
      `PLTQ_ST_ARMING: next_arm_st = `PLTQ_ST_ARMED;
      `PLTQ_ST_ARMED: begin
        if (any_hit & ~meas_clr) begin
          next_arm_st = `PLTQ_ST_IDLE;
        end
      end
      default: next_arm_st = `PLTQ_ST_IDLE;
    endcase
    if (disarm_cmd) begin
      next_arm_st = `PLTQ_ST_IDLE;
    end
  end

  wire fire = (arm_st == `PLTQ_ST_ARMED) & any_hit & ~meas_clr & ~disarm_cmd;

  always @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      arm_st <= `PLTQ_ST_IDLE;
      trig_seen <= 1'b0;
      o_trigger <= 1'b0;
      o_armed <= 1'b0;
    end else begin
      arm_st <= next_arm_st;
      o_trigger <= fire;
      o_armed <= (next_arm_st == `PLTQ_ST_ARMED);
      if (fire) begin
        trig_seen <= 1'b1;
      end else if (arm_cmd) begin
        trig_seen <= 1'b0;
      end
    end
  end

endmodule

// >>> tb/pltq_chan_model.sv
`timescale 1ns/10ps
module pltq_chan_model (
  // Line levels from the bench
  input wire [3:0] i_level,
  // Digitized samples, channel 1 in the low byte
  output wire [31:0] o_sample
);
  // One step above the reset threshold for high, at it for low: the tightest legal margin
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_ch
      assign o_sample[8*g+7:8*g] = i_level[g] ? 8'h81 : 8'h80;
    end
  endgenerate
endmodule

// >>> tb/pltq_checker_sva.sv
`timescale 1ns/10ps
module pltq_checker (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rst_b,
  // Bus
  input wire i_avs_read,
  input wire i_avs_write,
  input wire [31:0] o_avs_readdata,
  input wire o_avs_waitrequest,
  // Trigger
  input wire o_trigger,
  input wire o_armed
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  wire req = i_avs_read | i_avs_write;
  property p_wait_answer; req && o_avs_waitrequest |=> !o_avs_waitrequest; endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("bus answer late");
  property p_wait_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer longer than one cycle");
  property p_wait_rest; !req && o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_wait_rest: assert property (p_wait_rest) else $error("answer without request");
  property p_wait_cause; !o_avs_waitrequest |-> $past(req); endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("answer without cause");
  property p_rd_hold; $changed(o_avs_readdata) |-> $past(i_avs_read) && !o_avs_waitrequest;
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved between reads");
  // A trigger can only leave a cycle that was armed
  property p_trig_armed; o_trigger |-> $past(o_armed); endproperty
  a_trig_armed: assert property (p_trig_armed) else $error("trigger while unarmed");
  property p_trig_single; o_trigger |=> !o_trigger [*3]; endproperty
  a_trig_single: assert property (p_trig_single) else $error("trigger not single");
  property p_trig_disarm; o_trigger |=> !o_armed; endproperty
  a_trig_disarm: assert property (p_trig_disarm) else $error("armed after trigger");
  property p_armed_cause; $rose(o_armed) |-> $past(i_avs_write) || $past(i_avs_write, 2);
  endproperty
  a_armed_cause: assert property (p_armed_cause) else $error("armed without write");
  c_trig: cover property (o_trigger);
  c_arm: cover property ($rose(o_armed));
  c_read: cover property (i_avs_read && !o_avs_waitrequest);
endmodule
bind pulse_logic_trigger_qualifier pltq_checker i_chk (.i_sys_clk(i_sys_clk),
  .i_rst_b(i_rst_b), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
  .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
  .o_trigger(o_trigger), .o_armed(o_armed));

// >>> tb/tb_pulse_logic_trigger_qualifier.sv
`timescale 1ns/10ps
`include "pltq_defs.vh"
module tb_pulse_logic_trigger_qualifier;
  reg i_sys_clk, i_rst_b, rd, wr, outside_trigger_input, done1, done2, e1, e2;
  reg [5:0] adr;
  reg [31:0] wdat, t1, t2;
  reg [3:0] be, lvl, hi, care, lv, pv;
  reg [17:0] pc;
  wire [31:0] samp, q1, q2;
  wire wt1, trig1, trig2, arm1;
  integer bad_count, n_tests, seed, i, j, f1, f2, d1, d2, k;
  pltq_chan_model i_chan (.i_level(lvl), .o_sample(samp));
  pulse_logic_trigger_qualifier #(.FOUR_CHAN(1)) i_dut (.i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdat), .i_avs_byteenable(be), .o_avs_readdata(q1),
    .o_avs_waitrequest(wt1), .i_chan_sample(samp), .i_outside_trigger_input(outside_trigger_input),
    .o_trigger(trig1), .o_armed(arm1));
  // Two-channel variant shares the bus; its answer timing is the same
  pulse_logic_trigger_qualifier #(.FOUR_CHAN(0)) i_dut_two (.i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b), .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wdat), .i_avs_byteenable(be), .o_avs_readdata(q2),
    .o_avs_waitrequest(), .i_chan_sample(samp), .i_outside_trigger_input(outside_trigger_input),
    .o_trigger(trig2), .o_armed());
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task summarize;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("TB: PASS");
      else
        $display("TB: FAIL");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("BAD %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task bus(input w, input [5:0] a, input [31:0] d, input [3:0] b);
    integer m;
    begin
      @(posedge i_sys_clk);
      adr <= a;
      wr <= w;
      rd <= !w;
      wdat <= d;
      be <= b;
      m = 0;
      @(posedge i_sys_clk);
      while (wt1 !== 1'b0 && m < 20) begin
        @(posedge i_sys_clk);
        m = m + 1;
      end
      t1 = q1;
      t2 = q2;
      rd <= 1'b0;
      wr <= 1'b0;
      if (m == 20) begin
        bad_count = bad_count + 1;
        summarize;
      end
    end
  endtask
  task w32(input [5:0] a, input [31:0] d);
    bus(1'b1, a, d, 4'hF);
  endtask
  task r32(input [5:0] a);
    bus(1'b0, a, 32'h0, 4'hF);
  endtask
  // Flags whether each variant shows a trigger cycle over n edges
  task watch(input integer n);
    begin
      f1 = 0;
      f2 = 0;
      repeat (n) begin
        @(posedge i_sys_clk);
        f1 = f1 | (trig1 === 1'b1);
        f2 = f2 | (trig2 === 1'b1);
      end
    end
  endtask
  task pulse(input neg, input integer len);
    integer m;
    begin
      f1 = 0;
      d1 = 0;
      @(posedge i_sys_clk);
      lvl[0] <= !neg;
      for (m = 1; m <= len + 20; m = m + 1) begin
        @(posedge i_sys_clk);
        if (m == len)
          lvl[0] <= neg;
        if (trig1 === 1'b1 && f1 == 0) begin
          f1 = 1;
          d1 = m;
        end
      end
    end
  endtask
  function lfun(input [1:0] fn, input [3:0] l, input [3:0] h, input [3:0] c);
    reg [3:0] mt;
    begin
      mt = ~(l ^ h) & c;
      case (fn)
        2'h0: lfun = (mt == c);
        2'h1: lfun = (mt != c);
        2'h2: lfun = (mt != 4'h0);
        default: lfun = (mt == 4'h0);
      endcase
    end
  endfunction
  // Pulse config, pulse is negative, length, trigger expected; widths 6, 4..8, 5
  function [17:0] pcase(input integer n);
    case (n)
      0: pcase = {8'h00, 1'b0, 8'h07, 1'b1};
      1: pcase = {8'h00, 1'b0, 8'h05, 1'b0};
      2: pcase = {8'h40, 1'b0, 8'h05, 1'b1};
      3: pcase = {8'h00, 1'b1, 8'h07, 1'b0};
      4: pcase = {8'h08, 1'b1, 8'h07, 1'b1};
      5: pcase = {8'h04, 1'b1, 8'h07, 1'b1};
      6: pcase = {8'h01, 1'b0, 8'h06, 1'b1};
      7: pcase = {8'h01, 1'b0, 8'h09, 1'b0};
      8: pcase = {8'h81, 1'b0, 8'h09, 1'b1};
      9: pcase = {8'h81, 1'b0, 8'h03, 1'b1};
      10: pcase = {8'h11, 1'b0, 8'h06, 1'b0};
      11: pcase = {8'h11, 1'b1, 8'h06, 1'b1};
      default: pcase = {8'h22, 1'b1, 8'h03, 1'b1};
    endcase
  endfunction
  initial begin
    i_rst_b = 1'b0;
    adr = 6'h00;
    rd = 1'b0;
    wr = 1'b0;
    wdat = 32'h0;
    be = 4'hF;
    lvl = 4'h0;
    outside_trigger_input = 1'b0;
    bad_count = 0;
    n_tests = 0;
    seed = 32'hB32D;
    repeat (2) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    r32(6'h14);
    chk("upper_w", `PLTQ_RST_UPPER, t1);
    r32(6'h20);
    chk("thr", {24'h0, `PLTQ_RST_THR}, t1);
    r32(6'h2C);
    chk("unmapped", 32'h0, t1);
    r32(6'h28);
    chk("stat4", 32'h8, t1 & 32'h1F);
    chk("stat2", 32'h0, t2 & 32'h1F);
    bus(1'b1, 6'h0C, 32'hFFFFFF06, 4'h1);
    r32(6'h0C);
    chk("lane", 32'h6, t1);
    w32(6'h10, 32'h4);
    w32(6'h14, 32'h8);
    w32(6'h18, 32'h5);
    w32(6'h00, 32'h100);
    r32(6'h00);
    chk("second", 32'h0, t1 & 32'h300);
    w32(6'h04, 32'h400);
    r32(6'h04);
    chk("state4", 32'h400, t1 & 32'h400);
    chk("state2", 32'h0, t2 & 32'h400);
    w32(6'h08, 32'h02);
    w32(6'h00, 32'h8);
    pulse(1'b0, 12);
    chk("early", 0, f1);
    w32(6'h00, 32'h9);
    pulse(1'b0, 12);
    d2 = d1;
    chk("forced", 1, f1);
    chk("disarm", 0, arm1);
    k = 2 + {$random(seed)} % 3;
    w32(6'h00, 32'h9);
    pulse(1'b0, k);
    chk("trailing", 1, f1);
    chk("lag", d2 - 5, d1 - k);
    for (i = 0; i < 13; i = i + 1) begin
      pc = pcase(i);
      lvl[0] <= pc[9];
      w32(6'h08, {24'h0, pc[17:10]});
      w32(6'h00, 32'h9);
      pulse(pc[9], pc[8:1]);
      chk("pulse", pc[0], f1);
    end
    // Pulse started before a config write must not qualify, though it is wide
    lvl[0] <= 1'b0;
    w32(6'h08, 32'h0);
    w32(6'h00, 32'h9);
    repeat (3) @(posedge i_sys_clk);
    lvl[0] <= 1'b1;
    repeat (2) @(posedge i_sys_clk);
    w32(6'h0C, 32'h6);
    repeat (7) @(posedge i_sys_clk);
    lvl[0] <= 1'b0;
    watch(12);
    chk("restart", 0, f1);
    chk("armed", 1, arm1);
    for (i = 0; i < 4; i = i + 1) begin
      hi = $random(seed);
      care = $random(seed) | 4'h3;
      for (j = 0; j < 16; j = j + 1)
        if (!lfun(i[1:0], j[3:0], hi, care) && !lfun(i[1:0], j[3:0], hi, care & 4'h3))
          pv = j;
      lvl <= pv;
      w32(6'h04, {22'h0, i[1:0], care, hi});
      w32(6'h00, 32'h45);
      // Patterns that come true while arming are discarded, so wait it out
      repeat (2) @(posedge i_sys_clk);
      done1 = 1'b0;
      done2 = 1'b0;
      for (j = 0; j < 10; j = j + 1) begin
        lv = $random(seed);
        lvl <= lv;
        outside_trigger_input <= $random(seed);
        watch(6);
        e1 = !done1 && lfun(i[1:0], lv, hi, care) && !lfun(i[1:0], pv, hi, care);
        e2 = !done2 && lfun(i[1:0], lv, hi, care & 4'h3) && !lfun(i[1:0], pv, hi, care & 4'h3);
        chk("logic4", e1, f1);
        chk("logic2", e2, f2);
        done1 = done1 | e1;
        done2 = done2 | e2;
        pv = lv;
      end
    end
    // State class clocks on channel 4; the two-channel part falls back to pattern
    lvl <= 4'h6;
    w32(6'h04, 32'h477);
    w32(6'h00, 32'h5);
    repeat (2) @(posedge i_sys_clk);
    for (j = 0; j < 3; j = j + 1) begin
      lvl <= (j == 0) ? 4'hE : (j == 1) ? 4'h7 : 4'hF;
      watch(5);
      chk("clk4", j == 2, f1);
      chk("fall2", j == 1, f2);
    end
    // Pattern true for three cycles is short of width 4; held longer it fires
    lvl <= 4'h0;
    w32(6'h1C, 32'h4);
    w32(6'h04, 32'h1011);
    w32(6'h00, 32'h5);
    repeat (2) @(posedge i_sys_clk);
    lvl <= 4'h1;
    watch(3);
    lvl <= 4'h0;
    watch(4);
    chk("qual_short", 0, f1 | f2);
    lvl <= 4'h1;
    watch(8);
    chk("qual4", 1, f1);
    chk("qual2", 1, f2);
    summarize;
  end
endmodule
